// *** rtl/apm_top.sv ***
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module apm_top #(
    parameter int NUM_PINS      = apm_pkg::NUM_PINS,
    parameter int SETTLE_CYCLES = apm_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // Register port
    input  wire logic [7:0]             regAddr,
    input  wire logic [15:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic [15:0]                 regRdata,
    // Conversion clock gate and external triggers
    input  wire logic                   convClkEn,
    input  wire logic [3:0]             extTrig,
    // Analog array interface
    input  wire logic                   cmpHigh,
    output logic [11:0]                 trialCode,
    output logic                        sampleOn,
    output logic [3:0]                  analogChannel,
    output logic                        bandgapEn,
    output logic                        referenceEn,
    output logic                        coreEn,
    output logic                        comparatorsEn,
    // Shared analog pins, digital side
    input  wire logic [NUM_PINS-1:0]    pinIn,
    output logic [NUM_PINS-1:0]         pinOut,
    output logic [NUM_PINS-1:0]         pinOe,
    output logic [NUM_PINS-1:0]         pinInBufEn
);
    localparam int NS = apm_pkg::NUM_SLOTS;
    localparam int RB = apm_pkg::RESULT_BITS;

    apm_conv_if cv ();

    // Power and mode
    logic [2:0]            pwr_ff;
    logic [31:0]           settleCnt_ff;
    logic                  settled_ff;
    apm_pkg::apm_mode_t    mode;
    // Conversion clock divider
    logic [7:0]            div_ff;
    logic                  convTick_ff;
    // Slots
    logic [15:0]           slotCtl_ff [NS];
    logic [RB-1:0]         result_ff  [NS];
    logic [NS-1:0]         pend_ff;
    logic [NS-1:0]         done_ff;
    logic [3:0]            curSlot_ff;
    logic                  active_ff;
    logic [3:0]            extTrig_ff;
    // Outputs
    logic [15:0]           rdata_ff;
    logic [11:0]           trialCode_ff;
    logic                  sampleOn_ff;
    logic [3:0]            channel_ff;
    logic [3:0]            anaEn_ff;

    wire logic [11:0]         engTrial;
    wire logic                engSample;
    wire logic [NUM_PINS-1:0] selVal;
    wire logic [NUM_PINS-1:0] dirVal;
    wire logic [NUM_PINS-1:0] datRead;
    wire logic [NUM_PINS-1:0] muxOut;
    wire logic [NUM_PINS-1:0] muxOe;
    wire logic [NUM_PINS-1:0] muxInBuf;

    // Address decode
    wire logic isSlot   = (regAddr[7:4] == apm_pkg::OFS_SLOTBASE[7:4]);
    wire logic isResult = (regAddr[7:4] == apm_pkg::OFS_RESBASE[7:4]);
    wire logic [3:0] idx = regAddr[3:0];
    wire logic wrPower  = regWr && (regAddr == apm_pkg::OFS_POWER);
    wire logic wrSel    = regWr && (regAddr == apm_pkg::OFS_PINSEL);
    wire logic wrDat    = regWr && (regAddr == apm_pkg::OFS_PINDAT);
    wire logic wrDir    = regWr && (regAddr == apm_pkg::OFS_PINDIR);
    wire logic wrTrig   = regWr && (regAddr == apm_pkg::OFS_TRIGGER);
    wire logic wrSlot   = regWr && isSlot;

    assign mode = apm_pkg::decodeMode(pwr_ff);

    // Conversions only in operating mode with the conversion clock running
    wire logic coreReady = (mode == apm_pkg::APM_MODE_OPER) && convClkEn;

    // Slot trigger sources: 0 software only, 1..4 external lines
    function automatic logic slotHit(input logic [15:0] ctl, input logic [3:0] rise);
        logic [4:0] src;
        src = ctl[apm_pkg::SLOT_TRG_LSB +: 5];
        if (src >= 5'd1 && src <= 5'd4)
            return rise[src[1:0] - 2'd1];
        else
            return 1'b0;
    endfunction : slotHit

    wire logic [3:0] extRise = extTrig & ~extTrig_ff;
    logic [NS-1:0]   hwHit;
    always_comb
    begin
        for (int i = 0; i < NS; i++)
            hwHit[i] = slotHit(slotCtl_ff[i], extRise);
    end
    wire logic [NS-1:0] swHit = wrTrig ? regWdata : '0;

    // Lowest-numbered pending slot wins
    logic [3:0] nextSlot;
    logic       anyPend;
    always_comb
    begin
        nextSlot = '0;
        anyPend  = 1'b0;
        for (int i = NS - 1; i >= 0; i--)
            if (pend_ff[i])
            begin
                nextSlot = 4'(i);
                anyPend  = 1'b1;
            end
    end

    wire logic launch = anyPend && !active_ff && !cv.busy && coreReady;

    assign cv.start   = launch;
    assign cv.channel = slotCtl_ff[nextSlot][apm_pkg::SLOT_CH_LSB +: 4];
    assign cv.window  = slotCtl_ff[nextSlot][apm_pkg::SLOT_WIN_LSB +: 6];

    apm_conv_engine #(
        .RESULT_BITS (RB)
    ) u_engine (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .convTick  (convTick_ff),
        .coreReady (coreReady),
        .cmpHigh   (cmpHigh),
        .trialCode (engTrial),
        .sampleOn  (engSample),
        .cv        (cv.engine)
    );

    apm_pin_mux #(
        .NUM_PINS (NUM_PINS)
    ) u_pins (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .selWr   (wrSel),
        .datWr   (wrDat),
        .dirWr   (wrDir),
        .wrData  (regWdata[NUM_PINS-1:0]),
        .pinIn   (pinIn),
        .pinOut  (muxOut),
        .pinOe   (muxOe),
        .inBufEn (muxInBuf),
        .selVal  (selVal),
        .dirVal  (dirVal),
        .datRead (datRead)
    );

    // Power bits written together in one access; settle timer restarts
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pwr_ff       <= apm_pkg::PWR_RESET;
            settleCnt_ff <= '0;
            settled_ff   <= 1'b0;
        end
        else if (wrPower)
        begin
            pwr_ff       <= regWdata[2:0];
            settleCnt_ff <= '0;
            settled_ff   <= 1'b0;
        end
        else if (mode != apm_pkg::APM_MODE_OPER)
        begin
            settleCnt_ff <= '0;
            settled_ff   <= 1'b0;
        end
        else if (settleCnt_ff >= 32'(SETTLE_CYCLES - 1))
            settled_ff <= 1'b1;
        else
            settleCnt_ff <= settleCnt_ff + 32'd1;
    end

    // Conversion clock enable
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || !convClkEn)
        begin
            div_ff      <= '0;
            convTick_ff <= 1'b0;
        end
        else
        begin
            convTick_ff <= (div_ff == 8'(apm_pkg::CONV_DIV - 1));
            div_ff      <= (div_ff == 8'(apm_pkg::CONV_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
        end
    end

    // Slot configuration, pending flags and results
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NS; i++)
            begin
                slotCtl_ff[i] <= apm_pkg::SLOT_RESET;
                result_ff[i]  <= '0;
            end
            pend_ff    <= '0;
            done_ff    <= '0;
            curSlot_ff <= '0;
            active_ff  <= 1'b0;
            extTrig_ff <= '0;
        end
        else
        begin
            extTrig_ff <= extTrig;
            if (wrSlot)
                slotCtl_ff[idx] <= regWdata;
            // New triggers win over the launch clear
            pend_ff <= (pend_ff & ~(launch ? (NS'(1) << nextSlot) : '0)) | swHit | hwHit;
            if (launch)
            begin
                curSlot_ff <= nextSlot;
                active_ff  <= 1'b1;
            end
            else if (cv.done || !coreReady)
                active_ff <= 1'b0;
            // Completed flag: set wins over a clear by reading the result
            done_ff <= (done_ff & ~((regRd && isResult) ? (NS'(1) << idx) : '0))
                     | ((cv.done && active_ff) ? (NS'(1) << curSlot_ff) : '0);
            if (cv.done && active_ff)
                result_ff[curSlot_ff] <= cv.code;
        end
    end

    // Read mux
    logic [15:0] rdNext;
    always_comb
    begin
        rdNext = '0;
        if (isSlot)
            rdNext = slotCtl_ff[idx];
        else if (isResult)
            rdNext = {{(16 - RB){1'b0}}, result_ff[idx]};
        else
            case (regAddr)
                apm_pkg::OFS_POWER:   rdNext = {13'h0000, pwr_ff};
                apm_pkg::OFS_STATUS:  rdNext = {11'h000, active_ff, settled_ff, coreReady, mode};
                apm_pkg::OFS_PINSEL:  rdNext = 16'(selVal);
                apm_pkg::OFS_PINDAT:  rdNext = 16'(datRead);
                apm_pkg::OFS_PINDIR:  rdNext = 16'(dirVal);
                apm_pkg::OFS_TRIGGER: rdNext = done_ff;
                default:              rdNext = '0;
            endcase
    end

    // Registered outputs
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            rdata_ff     <= '0;
            trialCode_ff <= '0;
            sampleOn_ff  <= 1'b0;
            channel_ff   <= '0;
            anaEn_ff     <= '0;
        end
        else
        begin
            rdata_ff     <= regRd ? rdNext : 16'h0000;
            trialCode_ff <= engTrial;
            sampleOn_ff  <= engSample;
            if (launch)
                channel_ff <= cv.channel;
            // Analog enables follow the mode; comparators stay on while bandgap is up
            anaEn_ff <= {pwr_ff[apm_pkg::PWR_BANDGAP_BIT],
                         pwr_ff[apm_pkg::PWR_CORE_BIT] & pwr_ff[apm_pkg::PWR_REF_BIT]
                             & pwr_ff[apm_pkg::PWR_BANDGAP_BIT],
                         pwr_ff[apm_pkg::PWR_REF_BIT] & pwr_ff[apm_pkg::PWR_BANDGAP_BIT],
                         pwr_ff[apm_pkg::PWR_BANDGAP_BIT]};
        end
    end

    assign regRdata      = rdata_ff;
    assign trialCode     = trialCode_ff;
    assign sampleOn      = sampleOn_ff;
    assign analogChannel = channel_ff;
    assign bandgapEn     = anaEn_ff[0];
    assign referenceEn   = anaEn_ff[1];
    assign coreEn        = anaEn_ff[2];
    assign comparatorsEn = anaEn_ff[3];
    assign pinOut        = muxOut;
    assign pinOe         = muxOe;
    assign pinInBufEn    = muxInBuf;
endmodule : apm_top
`default_nettype wire

// *** rtl/apm_pkg.sv ***
package apm_pkg;

    // Register offsets on the plain register port (word index)
    localparam logic [7:0] OFS_POWER    = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h01;
    localparam logic [7:0] OFS_PINSEL   = 8'h02;
    localparam logic [7:0] OFS_PINDAT   = 8'h03;
    localparam logic [7:0] OFS_PINDIR   = 8'h04;
    localparam logic [7:0] OFS_TRIGGER  = 8'h05;
    localparam logic [7:0] OFS_SLOTBASE = 8'h10;
    localparam logic [7:0] OFS_RESBASE  = 8'h20;

    // Power register fields
    localparam int PWR_BANDGAP_BIT = 0;
    localparam int PWR_REF_BIT     = 1;
    localparam int PWR_CORE_BIT    = 2;

    // Slot control fields: channel [3:0], sample window [9:4], trigger [14:10]
    localparam int SLOT_CH_LSB  = 0;
    localparam int SLOT_WIN_LSB = 4;
    localparam int SLOT_TRG_LSB = 10;

    localparam int NUM_SLOTS    = 16;
    localparam int NUM_PINS     = 8;
    localparam int RESULT_BITS  = 12;
    localparam int FULL_CODES   = 4096;

    // Reset values
    localparam logic [2:0]  PWR_RESET    = 3'h0;
    localparam logic [15:0] SLOT_RESET   = 16'h0000;
    localparam logic [15:0] PINSEL_RESET = 16'hffff;

    // Conversion timing
    localparam int CLK_MHZ        = 100;
    localparam int CONV_DIV       = 2;
    localparam int CONV_BIT_TICKS = 13;
    localparam int SETTLE_US      = 1000;
    localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        APM_MODE_OFF   = 2'b00,
        APM_MODE_COMP  = 2'b01,
        APM_MODE_QUICK = 2'b11,
        APM_MODE_OPER  = 2'b10
    } apm_mode_t;

    typedef enum logic [1:0] {
        APM_CV_IDLE   = 2'b00,
        APM_CV_SAMPLE = 2'b01,
        APM_CV_CONV   = 2'b11,
        APM_CV_STORE  = 2'b10
    } apm_conv_t;

    function automatic apm_mode_t decodeMode(input logic [2:0] pwr);
        if (pwr[PWR_BANDGAP_BIT] && pwr[PWR_REF_BIT] && pwr[PWR_CORE_BIT])
            return APM_MODE_OPER;
        else if (pwr[PWR_BANDGAP_BIT] && pwr[PWR_REF_BIT])
            return APM_MODE_QUICK;
        else if (pwr[PWR_BANDGAP_BIT])
            return APM_MODE_COMP;
        else
            return APM_MODE_OFF;
    endfunction : decodeMode

endpackage : apm_pkg

// *** rtl/apm_conv_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Request and answer between the slot scheduler and the conversion engine
interface apm_conv_if;
    logic       start;
    logic [3:0] channel;
    logic [5:0] window;
    logic       busy;
    logic       done;
    logic [11:0] code;

    modport sched (output start, output channel, output window,
                   input busy, input done, input code);
    modport engine (input start, input channel, input window,
                    output busy, output done, output code);
endinterface : apm_conv_if
`default_nettype wire

// *** rtl/apm_conv_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module apm_conv_engine #(
    parameter int RESULT_BITS = 12
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // Conversion clock enable and core readiness
    input  wire logic                   convTick,
    input  wire logic                   coreReady,
    // Comparator decision from the analog successive approximation array
    input  wire logic                   cmpHigh,
    // Trial code presented to the analog array
    output logic [RESULT_BITS-1:0]      trialCode,
    output logic                        sampleOn,
    // Scheduler side
    apm_conv_if.engine                  cv
);
    apm_pkg::apm_conv_t          state_ff;
    apm_pkg::apm_conv_t          nxt_state;
    logic [5:0]                  cnt_ff;
    logic [5:0]                  nxt_cnt;
    logic [RESULT_BITS-1:0]      sar_ff;
    logic [RESULT_BITS-1:0]      nxt_sar;
    logic [RESULT_BITS-1:0]      bitMask_ff;
    logic [RESULT_BITS-1:0]      nxt_bitMask;
    logic                        done_ff;

    wire logic [RESULT_BITS-1:0] trial = sar_ff | bitMask_ff;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_sar     = sar_ff;
        nxt_bitMask = bitMask_ff;
        case (state_ff)
            apm_pkg::APM_CV_IDLE:
                if (cv.start && coreReady)
                begin
                    nxt_state = apm_pkg::APM_CV_SAMPLE;
                    nxt_cnt   = cv.window;
                end
            apm_pkg::APM_CV_SAMPLE:
                if (!coreReady)
                    nxt_state = apm_pkg::APM_CV_IDLE;
                else if (convTick)
                begin
                    if (cnt_ff == 6'h00)
                    begin
                        nxt_state   = apm_pkg::APM_CV_CONV;
                        nxt_sar     = '0;
                        nxt_bitMask = {1'b1, {(RESULT_BITS-1){1'b0}}};
                    end
                    else
                        nxt_cnt = cnt_ff - 6'h01;
                end
            apm_pkg::APM_CV_CONV:
                if (!coreReady)
                    nxt_state = apm_pkg::APM_CV_IDLE;
                else if (convTick)
                begin
                    // Successive approximation: keep the trial bit when input is above it
                    if (cmpHigh)
                        nxt_sar = trial;
                    nxt_bitMask = bitMask_ff >> 1;
                    if (bitMask_ff[0])
                        nxt_state = apm_pkg::APM_CV_STORE;
                end
            apm_pkg::APM_CV_STORE:
                nxt_state = apm_pkg::APM_CV_IDLE;
            default:
                nxt_state = apm_pkg::APM_CV_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_ff   <= apm_pkg::APM_CV_IDLE;
            cnt_ff     <= '0;
            sar_ff     <= '0;
            bitMask_ff <= '0;
            done_ff    <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            sar_ff     <= nxt_sar;
            bitMask_ff <= nxt_bitMask;
            done_ff    <= (state_ff == apm_pkg::APM_CV_STORE);
        end
    end

    assign trialCode = trial;
    assign sampleOn  = (state_ff == apm_pkg::APM_CV_SAMPLE);
    assign cv.busy   = (state_ff != apm_pkg::APM_CV_IDLE) || done_ff;
    assign cv.done   = done_ff;
    assign cv.code   = sar_ff;
endmodule : apm_conv_engine
`default_nettype wire

// *** rtl/apm_pin_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module apm_pin_mux #(
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // Register writes
    input  wire logic                selWr,
    input  wire logic                datWr,
    input  wire logic                dirWr,
    input  wire logic [NUM_PINS-1:0] wrData,
    // Pin side
    input  wire logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_PINS-1:0]      pinOut,
    output logic [NUM_PINS-1:0]      pinOe,
    output logic [NUM_PINS-1:0]      inBufEn,
    // Register views
    output logic [NUM_PINS-1:0]      selVal,
    output logic [NUM_PINS-1:0]      dirVal,
    output logic [NUM_PINS-1:0]      datRead
);
    logic [NUM_PINS-1:0] sel_ff;
    logic [NUM_PINS-1:0] latch_ff;
    logic [NUM_PINS-1:0] dir_ff;
    logic [NUM_PINS-1:0] pinOut_ff;
    logic [NUM_PINS-1:0] pinOe_ff;
    logic [NUM_PINS-1:0] inBuf_ff;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sel_ff    <= apm_pkg::PINSEL_RESET[NUM_PINS-1:0];
            latch_ff  <= '0;
            dir_ff    <= '0;
            pinOut_ff <= '0;
            pinOe_ff  <= '0;
            inBuf_ff  <= '0;
        end
        else
        begin
            if (selWr)
                sel_ff <= wrData;
            if (datWr)
                latch_ff <= wrData;
            if (dirWr)
                dir_ff <= wrData;
            // Digital drive only where the pin is released to digital use
            pinOut_ff <= latch_ff;
            pinOe_ff  <= dir_ff & ~sel_ff;
            inBuf_ff  <= ~sel_ff;
        end
    end

    // Live level when digital, output latch when analog
    assign datRead = (~sel_ff & pinIn) | (sel_ff & latch_ff);
    assign selVal  = sel_ff;
    assign dirVal  = dir_ff;
    assign pinOut  = pinOut_ff;
    assign pinOe   = pinOe_ff;
    assign inBufEn = inBuf_ff;
endmodule : apm_pin_mux
`default_nettype wire

// *** testbench/apm_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module apm_top_props #(
    parameter int NUM_PINS = 8
) (
    // Clock, reset and register port
    input wire logic                ref_clk,
    input wire logic                rstn,
    input wire logic [7:0]          regAddr,
    input wire logic [15:0]         regWdata,
    input wire logic                regWr,
    input wire logic                regRd,
    input wire logic [15:0]         regRdata,
    // Analog enables
    input wire logic                sampleOn,
    input wire logic                bandgapEn,
    input wire logic                referenceEn,
    input wire logic                coreEn,
    input wire logic                comparatorsEn,
    // Shared pins
    input wire logic [NUM_PINS-1:0] pinIn,
    input wire logic [NUM_PINS-1:0] pinOe,
    input wire logic [NUM_PINS-1:0] pinInBufEn
);
    logic pwrWr;
    logic pinRd;
    logic allOn;
    logic refOn;
    assign pwrWr = regWr && regAddr == 8'h00;
    assign pinRd = regRd && regAddr == 8'h03;
    assign allOn = &regWdata[2:0];
    assign refOn = regWdata[1] & regWdata[0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_CORE_EN: assert property (pwrWr |-> ##2 coreEn == $past(allOn, 2))
        else $error("core enable wrong after power write");
    AST_REF_EN: assert property (pwrWr |-> ##2 referenceEn == $past(refOn, 2))
        else $error("reference enable wrong after power write");
    AST_BG_EN: assert property (pwrWr |-> ##2 bandgapEn == $past(regWdata[0], 2))
        else $error("bandgap enable wrong after power write");
    AST_COMP_BG: assert property (comparatorsEn == bandgapEn)
        else $error("comparator enable differs from bandgap");
    AST_NO_SAMPLE: assert property (!coreEn [*3] |-> !sampleOn)
        else $error("sampling with core off");
    AST_BUF_OE: assert property ((pinOe & ~pinInBufEn) == '0)
        else $error("pin driven with input buffer off");
    AST_RD_PIN: assert property ((pinRd && $stable(pinInBufEn)) |=>
        ((regRdata[NUM_PINS-1:0] ^ $past(pinIn)) & pinInBufEn) == '0)
        else $error("pin data read misses live level");
    AST_RST: assert property (disable iff (1'b0) !rstn |=>
        pinInBufEn == '0 && pinOe == '0 && !bandgapEn)
        else $error("pin or power state wrong after reset");
    cover property (coreEn && sampleOn);
    cover property (pwrWr && regWdata[2:0] == 3'h7);
    cover property (pinRd && pinInBufEn != '0 && pinInBufEn != '1);
endmodule : apm_top_props
bind apm_top apm_top_props #(.NUM_PINS(NUM_PINS)) u_props (.ref_clk, .rstn, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .sampleOn, .bandgapEn, .referenceEn, .coreEn,
    .comparatorsEn, .pinIn, .pinOe, .pinInBufEn);
`default_nettype wire

// *** testbench/apm_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module apm_top_test;
    logic ref_clk = 0, rstn = 0, regWr = 0, regRd = 0, convClkEn = 0, p1 = 0, sampleOn;
    logic [7:0] regAddr = '0, pinIn = '0, pinOut, pinOe, pinInBufEn;
    logic [15:0] regWdata = '0, regRdata, lfsrState = 16'ha62e;
    logic [3:0] extTrig = '0, analogChannel, sl;
    logic [11:0] trialCode, vin = '0;
    logic bandgapEn, referenceEn, coreEn, comparatorsEn;
    logic [2:0] pw;
    logic [1:0] md;
    logic [31:0] expQ[$];
    logic [31:0] expV;
    int errTotal = 0, comparisons = 0;
    // Ideal comparator: input at or above the trial code
    wire cmpHigh = vin >= trialCode;
    apm_top #(.SETTLE_CYCLES(50)) u_dut (.ref_clk, .rstn, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .convClkEn, .extTrig, .cmpHigh, .trialCode, .sampleOn,
        .analogChannel, .bandgapEn, .referenceEn, .coreEn, .comparatorsEn, .pinIn,
        .pinOut, .pinOe, .pinInBufEn);
    initial forever #5 ref_clk = ~ref_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Expected entries are {mask, value}
    task automatic chk(input logic [15:0] got, input logic [31:0] e);
        comparisons++;
        if (((got ^ e[15:0]) & e[31:16]) !== 16'h0000)
        begin
            errTotal++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e[15:0]);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        regRd <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        regAddr <= a;
        regRd <= 1'b1;
        regWr <= 1'b0;
        expQ.push_back({m, e});
        @(posedge ref_clk);
    endtask : rd
    task automatic idle(input int n);
        regWr <= 1'b0;
        regRd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask : idle
    task automatic results;
        $display("comparisons=%0d mismatches=%0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        p1 <= regRd;
        if (p1 && expQ.size() > 0)
            chk(regRdata, expQ.pop_front());
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errTotal++;
        $display("watchdog expired");
        results();
    end
    initial
    begin
        idle(10);
        rstn <= 1'b1;
        idle(1);
        rd(8'h00, 16'h0000, 16'h0007);
        rd(8'h02, 16'h00ff, 16'h00ff);
        rd(8'h3f, 16'h0000, 16'hffff);
        idle(2);
        chk({8'h00, pinInBufEn}, 32'h00ff_0000);
        $display("reset test over");
        for (int m = 0; m < 8; m++)
        begin
            pw = m[2:0];
            md = !pw[0] ? 2'b00 : !pw[1] ? 2'b01 : pw[2] ? 2'b10 : 2'b11;
            lfsrState = lfsr(lfsrState);
            convClkEn <= lfsrState[0];
            wr(8'h00, {13'h0, pw});
            idle(3);
            expV = {16'hf, 12'h0, pw[0], &pw, &pw[1:0], pw[0]};
            chk({12'h0, comparatorsEn, coreEn, referenceEn, bandgapEn}, expV);
            rd(8'h01, {13'h0, md == 2'b10 && lfsrState[0], md}, 16'h0007);
        end
        $display("power mode test over");
        convClkEn <= 1'b1;
        wr(8'h00, 16'h0000);
        wr(8'h00, 16'h0007);
        idle(3);
        rd(8'h01, 16'h0000, 16'h0008);
        idle(60);
        rd(8'h01, 16'h0008, 16'h0008);
        $display("settle test over");
        for (int i = 0; i < 4; i++)
        begin
            lfsrState = lfsr(lfsrState);
            pinIn <= lfsrState[7:0];
            wr(8'h02, {8'h0, lfsrState[15:8]});
            wr(8'h04, 16'h00ff);
            wr(8'h03, {8'h0, ~lfsrState[7:0]});
            idle(3);
            rd(8'h03, {8'h0, lfsrState[7:0] ^ lfsrState[15:8]}, 16'h00ff);
            idle(2);
            chk({8'h0, pinOe}, {16'h00ff, 8'h0, ~lfsrState[15:8]});
            chk({8'h0, pinInBufEn}, {16'h00ff, 8'h0, ~lfsrState[15:8]});
            chk({8'h0, pinOut}, {16'h00ff, 8'h0, ~lfsrState[7:0]});
        end
        wr(8'h02, 16'h00ff);
        $display("pin test over");
        // Slot 0 by software, then slot 15 by each external trigger line in turn
        for (int k = 0; k < 5; k++)
        begin
            lfsrState = lfsr(lfsrState);
            vin <= lfsrState[11:0];
            sl = k ? 4'hf : 4'h0;
            wr({4'h1, sl}, k ? {1'b0, 5'(k), 10'h07a} : 16'h0005);
            if (k)
                extTrig <= 4'h1 << (k - 1);
            else
                wr(8'h05, 16'h0001);
            idle(6);
            chk({15'h0, sampleOn}, {16'h0001, 15'h0, k != 0});
            idle(144);
            rd(8'h05, 16'h0001 << sl, 16'h0001 << sl);
            rd({4'h2, sl}, {4'h0, lfsrState[11:0]}, 16'h0fff);
            rd(8'h05, 16'h0000, 16'h0001 << sl);
            idle(2);
            chk({12'h0, analogChannel}, {16'h000f, 12'h0, k ? 4'ha : 4'h5});
            chk({4'h0, trialCode}, {16'h0fff, 4'h0, lfsrState[11:0]});
        end
        $display("conversion test over");
        idle(2);
        results();
    end
endmodule : apm_top_test
`default_nettype wire
